// ### inc/cms_pkg.sv
// Package of codes, selections and carriers for the calibration mode selector
package cms_pkg;
    // ****************************************************************
    // Code widths and values
    // ****************************************************************
    localparam int TRACK_W = 2;
    localparam int CALIB_W = 3;
    localparam logic [1:0] TRACK_MASTER = 2'h0;
    localparam logic [1:0] TRACK_M = 2'h1;
    localparam logic [1:0] TRACK_S = 2'h2;
    localparam logic [1:0] TRACK_N = 2'h3;
    localparam logic [2:0] CAL_ANALOG = 3'h0;
    localparam logic [2:0] CAL_DIG_OFFSET = 3'h1;
    localparam logic [2:0] CAL_DIG_AMP = 3'h2;
    localparam logic [2:0] CAL_DIG_PHASE = 3'h3;
    localparam logic [2:0] CAL_RIPPLE = 3'h4;
    localparam logic [2:0] CAL_TEMP_WARN = 3'h5;
    localparam logic [2:0] CAL_TEMP_ERR = 3'h6;
    localparam logic [2:0] CAL_BUF_OFS = 3'h7;

    // ****************************************************************
    // Operating modes
    // ****************************************************************
    typedef enum logic [3:0] {
        CMS_NORMAL = 4'b0000,
        CMS_ANALOG = 4'b0001,
        CMS_DIG_OFFSET = 4'b0010,
        CMS_DIG_AMP = 4'b0011,
        CMS_DIG_PHASE = 4'b0100,
        CMS_RIPPLE = 4'b0101,
        CMS_TEMP_WARN = 4'b0110,
        CMS_TEMP_ERR = 4'b0111,
        CMS_BUF_OFS = 4'b1000
    } cms_mode_t;

    // Line output source
    typedef enum logic [1:0] {
        LINE_MASTER = 2'b00,
        LINE_CALIB = 2'b01,
        LINE_RAW = 2'b10
    } cms_line_t;

    // Test pin A source
    typedef enum logic [2:0] {
        PA_ZERO = 3'b000,
        PA_SINE_DC = 3'b001,
        PA_CTRL = 3'b010,
        PA_TEMP_WARN = 3'b011,
        PA_TEMP_ERR = 3'b100,
        PA_BUF_OUT = 3'b101,
        PA_DIG_OFS_COS = 3'b110
    } cms_pina_t;

    // Test pin B source
    typedef enum logic [2:0] {
        PB_ZERO = 3'b000,
        PB_COSINE_DC = 3'b001,
        PB_WARN_TH = 3'b010,
        PB_ERR_TH = 3'b011,
        PB_BUF_IN = 3'b100,
        PB_DIG_OFS_SIN = 3'b101,
        PB_DIG_AMP = 3'b110,
        PB_DIG_PHASE = 3'b111
    } cms_pinb_t;

    // Configuration inputs
    typedef struct packed {
        logic [1:0] trackSelectCode;
        logic [2:0] calibrationModeCode;
        logic inputBypassBit;
    } cms_cfg_t;

    // Routing selections for the analog switch matrix
    typedef struct packed {
        cms_mode_t mode;
        cms_line_t lineSource;
        logic [1:0] channel;
        cms_pina_t testPinA;
        cms_pinb_t testPinB;
        logic dirBias;
        logic levelControllerOn;
        logic calibActive;
    } cms_route_t;

    localparam cms_route_t ROUTE_NORMAL = '{mode: CMS_NORMAL,
        lineSource: LINE_MASTER, channel: TRACK_MASTER,
        testPinA: PA_ZERO, testPinB: PB_ZERO, dirBias: 1'b0,
        levelControllerOn: 1'b0, calibActive: 1'b0};
endpackage : cms_pkg

// ### rtl/cms_decode.sv
// Combinational decoder from configuration codes to an operating mode
`timescale 1ns/1ps
module cms_decode (
    input wire cms_pkg::cms_cfg_t cfg,
    output cms_pkg::cms_mode_t mode
);
    always_comb begin
        mode = cms_pkg::CMS_NORMAL;
        if (cfg.trackSelectCode == cms_pkg::TRACK_MASTER) begin
            case (cfg.calibrationModeCode)
                cms_pkg::CAL_TEMP_WARN: mode = cms_pkg::CMS_TEMP_WARN;
                cms_pkg::CAL_TEMP_ERR: mode = cms_pkg::CMS_TEMP_ERR;
                cms_pkg::CAL_BUF_OFS: mode = cms_pkg::CMS_BUF_OFS;
                default: mode = cms_pkg::CMS_NORMAL;
            endcase
        end else begin
            case (cfg.calibrationModeCode)
                cms_pkg::CAL_ANALOG: mode = cms_pkg::CMS_ANALOG;
                cms_pkg::CAL_DIG_OFFSET: begin
                    mode = cms_pkg::CMS_DIG_OFFSET;
                end
                cms_pkg::CAL_DIG_AMP: mode = cms_pkg::CMS_DIG_AMP;
                cms_pkg::CAL_DIG_PHASE: mode = cms_pkg::CMS_DIG_PHASE;
                cms_pkg::CAL_RIPPLE: mode = cms_pkg::CMS_RIPPLE;
                default: mode = cms_pkg::CMS_NORMAL;
            endcase
        end
    end
endmodule : cms_decode

// ### rtl/cms_mode_select.sv
// Calibration mode selector: registered routing of line and test pins
`timescale 1ns/1ps
module cms_mode_select (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [1:0] trackSelectCode,
    input wire logic [2:0] calibrationModeCode,
    input wire logic inputBypassBit,
    output cms_pkg::cms_route_t route,
    output logic digitalCalibrationMode
);
    // ****************************************************************
    // Decode
    // ****************************************************************
    cms_pkg::cms_cfg_t cfg;
    cms_pkg::cms_mode_t decMode;
    cms_pkg::cms_route_t next_route;

    assign cfg = '{trackSelectCode: trackSelectCode,
        calibrationModeCode: calibrationModeCode,
        inputBypassBit: inputBypassBit};

    cms_decode u_decode (
        .cfg(cfg),
        .mode(decMode)
    );

    // ****************************************************************
    // Routing
    // ****************************************************************
    always_comb begin
        next_route = cms_pkg::ROUTE_NORMAL;
        next_route.mode = decMode;
        case (decMode)
            cms_pkg::CMS_ANALOG: begin
                next_route.channel = cfg.trackSelectCode;
                next_route.lineSource = cfg.inputBypassBit ?
                    cms_pkg::LINE_RAW : cms_pkg::LINE_CALIB;
                next_route.testPinA = cms_pkg::PA_SINE_DC;
                next_route.testPinB = cms_pkg::PB_COSINE_DC;
                next_route.calibActive = 1'b1;
            end
            cms_pkg::CMS_DIG_OFFSET: begin
                next_route.channel = cfg.trackSelectCode;
                next_route.lineSource = cms_pkg::LINE_CALIB;
                next_route.testPinA = cms_pkg::PA_DIG_OFS_COS;
                next_route.testPinB = cms_pkg::PB_DIG_OFS_SIN;
                next_route.calibActive = 1'b1;
            end
            cms_pkg::CMS_DIG_AMP: begin
                next_route.channel = cfg.trackSelectCode;
                next_route.lineSource = cms_pkg::LINE_CALIB;
                next_route.testPinB = cms_pkg::PB_DIG_AMP;
                next_route.calibActive = 1'b1;
            end
            cms_pkg::CMS_DIG_PHASE: begin
                next_route.channel = cfg.trackSelectCode;
                next_route.lineSource = cms_pkg::LINE_CALIB;
                next_route.testPinB = cms_pkg::PB_DIG_PHASE;
                next_route.calibActive = 1'b1;
            end
            cms_pkg::CMS_RIPPLE: begin
                next_route.channel = cfg.trackSelectCode;
                next_route.lineSource = cms_pkg::LINE_CALIB;
                next_route.testPinA = cms_pkg::PA_CTRL;
                next_route.levelControllerOn = 1'b1;
                next_route.calibActive = 1'b1;
            end
            cms_pkg::CMS_TEMP_WARN: begin
                next_route.testPinA = cms_pkg::PA_TEMP_WARN;
                next_route.testPinB = cms_pkg::PB_WARN_TH;
                next_route.dirBias = 1'b1;
                next_route.calibActive = 1'b1;
            end
            cms_pkg::CMS_TEMP_ERR: begin
                next_route.testPinA = cms_pkg::PA_TEMP_ERR;
                next_route.testPinB = cms_pkg::PB_ERR_TH;
                next_route.dirBias = 1'b1;
                next_route.calibActive = 1'b1;
            end
            cms_pkg::CMS_BUF_OFS: begin
                next_route.testPinA = cms_pkg::PA_BUF_OUT;
                next_route.testPinB = cms_pkg::PB_BUF_IN;
                next_route.calibActive = 1'b1;
            end
            default: next_route = cms_pkg::ROUTE_NORMAL;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            route <= cms_pkg::ROUTE_NORMAL;
        end else begin
            route <= next_route;
        end
    end

    assign digitalCalibrationMode =
        (route.mode == cms_pkg::CMS_DIG_OFFSET) ||
        (route.mode == cms_pkg::CMS_DIG_AMP) ||
        (route.mode == cms_pkg::CMS_DIG_PHASE);

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_NORMAL_ZERO: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (cfg == '0) |=> (route.lineSource == cms_pkg::LINE_MASTER &&
            route.testPinA == cms_pkg::PA_ZERO &&
            route.testPinB == cms_pkg::PB_ZERO))
        else $error("normal mode routing wrong");
    AST_NORMAL_IDLE: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (cfg == '0) |=> (route.mode == cms_pkg::CMS_NORMAL &&
            !route.calibActive && !route.dirBias &&
            !route.levelControllerOn))
        else $error("normal mode not idle");
    AST_ANALOG_CHAN: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (trackSelectCode != cms_pkg::TRACK_MASTER &&
            calibrationModeCode == cms_pkg::CAL_ANALOG)
        |=> (route.channel == $past(trackSelectCode) &&
            route.mode == cms_pkg::CMS_ANALOG))
        else $error("analog channel not selected");
    AST_ANALOG_LINE: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (route.mode == cms_pkg::CMS_ANALOG) |->
        (route.lineSource != cms_pkg::LINE_MASTER && route.calibActive))
        else $error("analog line source wrong");
    AST_ANALOG_PINS: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (route.mode == cms_pkg::CMS_ANALOG) |->
        (route.testPinA == cms_pkg::PA_SINE_DC &&
            route.testPinB == cms_pkg::PB_COSINE_DC))
        else $error("analog test pins wrong");
    AST_BYPASS: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (decMode == cms_pkg::CMS_ANALOG) |=>
        ((route.lineSource == cms_pkg::LINE_RAW) == $past(inputBypassBit)))
        else $error("bypass routing wrong");
    AST_RAW_ONLY_ANALOG: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (route.lineSource == cms_pkg::LINE_RAW) |->
        (route.mode == cms_pkg::CMS_ANALOG))
        else $error("raw inputs outside analog mode");
    AST_RIPPLE: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (trackSelectCode != cms_pkg::TRACK_MASTER &&
            calibrationModeCode == cms_pkg::CAL_RIPPLE) |=>
        (route.levelControllerOn && route.testPinA == cms_pkg::PA_CTRL))
        else $error("ripple mode wrong");
    AST_RIPPLE_ONLY: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        route.levelControllerOn |->
        (route.mode == cms_pkg::CMS_RIPPLE &&
            route.channel != cms_pkg::TRACK_MASTER))
        else $error("level controller on outside ripple mode");
    AST_TEMP: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (trackSelectCode == cms_pkg::TRACK_MASTER &&
            (calibrationModeCode == cms_pkg::CAL_TEMP_WARN ||
            calibrationModeCode == cms_pkg::CAL_TEMP_ERR)) |=>
        (route.dirBias && route.lineSource == cms_pkg::LINE_MASTER))
        else $error("temperature mode wrong");
    AST_TEMP_WARN_PINS: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (route.mode == cms_pkg::CMS_TEMP_WARN) |->
        (route.testPinA == cms_pkg::PA_TEMP_WARN &&
            route.testPinB == cms_pkg::PB_WARN_TH))
        else $error("warning temperature pins wrong");
    AST_TEMP_ERR_PINS: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (route.mode == cms_pkg::CMS_TEMP_ERR) |->
        (route.testPinA == cms_pkg::PA_TEMP_ERR &&
            route.testPinB == cms_pkg::PB_ERR_TH))
        else $error("error temperature pins wrong");
    AST_DIR_BIAS: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        route.dirBias |-> (route.mode == cms_pkg::CMS_TEMP_WARN ||
            route.mode == cms_pkg::CMS_TEMP_ERR))
        else $error("bias on direction pin outside temperature modes");
    AST_BUFFER: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (trackSelectCode == cms_pkg::TRACK_MASTER &&
            calibrationModeCode == cms_pkg::CAL_BUF_OFS) |=>
        (route.testPinA == cms_pkg::PA_BUF_OUT &&
            route.testPinB == cms_pkg::PB_BUF_IN && !route.dirBias))
        else $error("buffer offset mode wrong");
    AST_BUFFER_LINE: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (route.mode == cms_pkg::CMS_BUF_OFS) |->
        (route.lineSource == cms_pkg::LINE_MASTER &&
            route.channel == cms_pkg::TRACK_MASTER))
        else $error("buffer offset line source wrong");
    AST_DIGITAL: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        digitalCalibrationMode |-> (route.testPinB != cms_pkg::PB_ZERO &&
            route.testPinB != cms_pkg::PB_COSINE_DC))
        else $error("digital mode pin wrong");
    AST_DIGITAL_CHAN: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        digitalCalibrationMode |->
        (route.channel != cms_pkg::TRACK_MASTER &&
            route.lineSource == cms_pkg::LINE_CALIB))
        else $error("digital mode channel wrong");

    // ****************************************************************
    // Checks of undefined codes
    // ****************************************************************
    AST_UNDEFINED: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (trackSelectCode == cms_pkg::TRACK_MASTER &&
            calibrationModeCode != cms_pkg::CAL_ANALOG &&
            calibrationModeCode < cms_pkg::CAL_TEMP_WARN) |=>
        (route == cms_pkg::ROUTE_NORMAL))
        else $error("undefined code not normal");
    AST_UNDEFINED_HIGH: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (trackSelectCode != cms_pkg::TRACK_MASTER &&
            calibrationModeCode > cms_pkg::CAL_RIPPLE) |=>
        (route == cms_pkg::ROUTE_NORMAL))
        else $error("undefined high code not normal");
endmodule : cms_mode_select

// ### dv/cms_probe_model.sv
// Test equipment model probing test pin A and the calibration flag of the selector
`timescale 1ns/1ps
module cms_probe_model (
    input wire cms_pkg::cms_route_t route,
    output logic cyclicRequest,
    output logic [2:0] seenPinA
);
    // ****************************************************************
    // Probing
    // ****************************************************************
    // Cyclic position requests only while no calibration runs
    always_comb begin
        cyclicRequest = ~route.calibActive;
        seenPinA = route.testPinA;
    end
endmodule : cms_probe_model

// ### dv/cms_mode_select_tb.sv
// Self-checking bench for the calibration mode selector
`timescale 1ns/1ps
module cms_mode_select_tb;
    logic sysClk = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] track = 2'h1;
    logic [2:0] calibration_mode_code = 3'h0;
    logic bypass = 1'b1;
    logic digMode;
    logic cyclicReq;
    logic [2:0] seenPinA;
    cms_pkg::cms_route_t route;
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;

    cms_mode_select dut (.sys_clk(sysClk), .resetn(resetn),
        .trackSelectCode(track), .calibrationModeCode(calibration_mode_code),
        .inputBypassBit(bypass), .route(route),
        .digitalCalibrationMode(digMode));
    cms_probe_model probe (.route(route),
        .cyclicRequest(cyclicReq), .seenPinA(seenPinA));

    always #4 sysClk = ~sysClk;

    always @(posedge sysClk) begin
        cycles++;
        if (cycles == 1000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    // ****************************************************************
    // Expected routing and shared tasks
    // ****************************************************************
    function automatic cms_pkg::cms_route_t expR(input logic [1:0] t,
        input logic [2:0] m, input logic b);
        cms_pkg::cms_route_t r;
        r = cms_pkg::ROUTE_NORMAL;
        if ((t != 2'h0) == (m < 3'h5)) begin
            r.mode = cms_pkg::cms_mode_t'({1'b0, m} + 4'h1);
            r.channel = t;
            r.calibActive = 1'b1;
        end
        if (t != 2'h0 && m < 3'h5) begin
            r.lineSource = cms_pkg::LINE_CALIB;
            if (m == 3'h0) begin
                r.testPinA = cms_pkg::PA_SINE_DC;
                r.testPinB = cms_pkg::PB_COSINE_DC;
                if (b)
                    r.lineSource = cms_pkg::LINE_RAW;
            end else if (m == 3'h4) begin
                r.testPinA = cms_pkg::PA_CTRL;
                r.levelControllerOn = 1'b1;
            end else begin
                r.testPinB = cms_pkg::cms_pinb_t'(m + 3'h4);
                if (m == 3'h1)
                    r.testPinA = cms_pkg::PA_DIG_OFS_COS;
            end
        end else if (t == 2'h0 && m > 3'h4) begin
            r.dirBias = m != 3'h7;
            r.testPinA = cms_pkg::cms_pina_t'(m - 3'h2);
            r.testPinB = cms_pkg::cms_pinb_t'(m - 3'h3);
        end
        return r;
    endfunction : expR

    task automatic chk(input cms_pkg::cms_route_t e, input logic d);
        n_compared++;
        if (route !== e || digMode !== d || seenPinA !== e.testPinA ||
            cyclicReq !== !e.calibActive) begin
            error_cnt++;
            $display("wrong value at %0t: route %h want %h dig %b",
                $time, route, e, digMode);
        end
    endtask : chk

    // Drives at a falling edge, checks one falling edge later
    task automatic apply(input logic [1:0] t, input logic [2:0] m,
        input logic b);
        track = t;
        calibration_mode_code = m;
        bypass = b;
        @(posedge sysClk);
        @(negedge sysClk);
        chk(expR(t, m, b), t != 2'h0 && m != 3'h0 && m < 3'h4);
    endtask : apply

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic tPerTrack();
        for (int t = 1; t < 4; t++) begin
            apply(2'(t), 3'h0, 1'b0);
            apply(2'(t), 3'h0, 1'b1);
            apply(2'(t), 3'h4, 1'b1);
            for (int m = 1; m < 4; m++)
                apply(2'(t), 3'(m), 1'b0);
        end
        done("per track");
    endtask : tPerTrack

    task automatic tTrackZero();
        apply(2'h0, 3'h0, 1'b0);
        for (int m = 5; m < 8; m++) begin
            apply(2'h0, 3'(m), 1'b0);
            apply(2'h0, 3'(m), 1'b1);
        end
        done("track zero");
    endtask : tTrackZero

    task automatic tUndefined();
        apply(2'h0, 3'h0, 1'b1);
        for (int m = 1; m < 5; m++)
            apply(2'h0, 3'(m), 1'b0);
        for (int t = 1; t < 4; t++)
            apply(2'(t), 3'(t + 4), 1'b1);
        done("undefined codes");
    endtask : tUndefined

    task automatic tMidReset();
        apply(2'h2, 3'h4, 1'b0);
        resetn = 1'b0;
        #1;
        chk(cms_pkg::ROUTE_NORMAL, 1'b0);
        @(negedge sysClk);
        resetn = 1'b1;
        apply(2'h3, 3'h0, 1'b1);
        done("mid-run reset");
    endtask : tMidReset

    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (2) @(negedge sysClk);
        chk(cms_pkg::ROUTE_NORMAL, 1'b0);
        resetn = 1'b1;
        tTrackZero();
        tPerTrack();
        tUndefined();
        tMidReset();
        report_and_stop();
    end
endmodule : cms_mode_select_tb
